//--- logic/charge_pkg.sv
// constants, types and decode helpers for the charge mode front end
// assumes a 50 MHz mclk; durations are nominal figures at 1 MHz
`default_nettype none
package charge_pkg;
   // ************************************************************
   // tri-level codes, clocking and durations
   // ************************************************************
   localparam logic [1:0] TRI_LOW  = 2'h0;
   localparam logic [1:0] TRI_OPEN = 2'h1;
   localparam logic [1:0] TRI_HIGH = 2'h2;
   localparam int CLK_HZ        = 50_000_000;
   localparam int NOMINAL_HZ    = 1_000_000;
   localparam int US_CYCLES     = CLK_HZ / NOMINAL_HZ;
   localparam int US_PER_MS     = 1000;
   localparam int RESET_MS      = 700;
   localparam int TEST_MS       = 1000;
   localparam int PULSE_MS      = 1048;
   localparam int POLL_ON_MS    = 100;
   localparam int POLL_PERIOD_MS = 624;
   localparam int FLASH_MS      = 1000;
   localparam int TEN_HOURS     = 10;
   localparam int TEN_HOUR_MS   = TEN_HOURS * 3600 * 1000;
   localparam int TOP_PULSES    = 8;
   localparam int POR_CYCLES    = 3;
   // per-rate figures in rate index order
   localparam int TOP_S [9]    = '{40, 20, 13, 10, 7, 5, 4, 3, 2};
   localparam int MAINT_S [9]  = '{160, 80, 53, 40, 27, 20, 16, 13, 10};
   localparam int FAST_MIN [9] = '{21, 39, 57, 75, 110, 144, 212, 244, 275};
   // ************************************************************
   // register map and fields
   // ************************************************************
   localparam logic [3:0] CTRL_ADDR   = 4'h0;
   localparam logic [3:0] STATUS_ADDR = 4'h4;
   localparam logic [3:0] SELECT_ADDR = 4'h8;
   localparam int CTRL_RST_BIT = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [2:0] {
      M_TEST = 3'h0, M_DIRECT = 3'h1, M_FAST = 3'h2, M_DIS_ONLY = 3'h3,
      M_DIS_CHG = 3'h4, M_COND = 3'h5, M_TEN_HR = 3'h6
   } mode_e;
   typedef enum logic [3:0] {
      ST_RESET = 4'h0, ST_TEST = 4'h1, ST_POLL = 4'h2, ST_FAST = 4'h3,
      ST_TOP = 4'h4, ST_MAINT = 4'h5, ST_COND = 4'h6, ST_DISCH = 4'h7,
      ST_SHUT = 4'h8
   } state_e;
   typedef struct packed {
      logic [1:0] rate_a;
      logic [1:0] rate_b;
      logic [1:0] mode_a;
      logic [1:0] mode_b;
   } select_s;
   typedef struct packed {
      logic vin_above_ref;
      logic open_circuit_reference_over_2v3;
      logic open_circuit_reference_over_4v;
      logic cell_at_1v;
   } sense_s;
   // ************************************************************
   // decode helpers
   // ************************************************************
   // a floating or unknown code reads as open
   function automatic logic [1:0] tri_norm(input logic [1:0] c);
      return (c == TRI_LOW || c == TRI_HIGH) ? c : TRI_OPEN;
   endfunction
   function automatic logic [3:0] rate_index(input logic [1:0] a,
                                             input logic [1:0] b);
      logic [3:0] r;
      r = 4'h7;
      unique case ({tri_norm(a), tri_norm(b)})
         {TRI_LOW, TRI_LOW}:   r = 4'h0;
         {TRI_LOW, TRI_HIGH}:  r = 4'h1;
         {TRI_LOW, TRI_OPEN}:  r = 4'h2;
         {TRI_HIGH, TRI_LOW}:  r = 4'h3;
         {TRI_HIGH, TRI_OPEN}: r = 4'h4;
         {TRI_HIGH, TRI_HIGH}: r = 4'h5;
         {TRI_OPEN, TRI_LOW}:  r = 4'h6;
         {TRI_OPEN, TRI_OPEN}: r = 4'h7;
         {TRI_OPEN, TRI_HIGH}: r = 4'h8;
         default:              r = 4'h7;
      endcase
      return r;
   endfunction
   function automatic mode_e mode_decode(input logic [1:0] a,
                                         input logic [1:0] b);
      mode_e m;
      m = M_FAST;
      unique case ({tri_norm(a), tri_norm(b)})
         {TRI_LOW, TRI_LOW}:   m = M_TEST;
         {TRI_LOW, TRI_HIGH}:  m = M_DIRECT;
         {TRI_OPEN, TRI_LOW}:  m = M_DIS_ONLY;
         {TRI_HIGH, TRI_LOW}:  m = M_DIS_CHG;
         {TRI_HIGH, TRI_OPEN}: m = M_COND;
         {TRI_HIGH, TRI_HIGH}: m = M_TEN_HR;
         default:              m = M_FAST;
      endcase
      return m;
   endfunction
endpackage
`default_nettype wire

//--- logic/charge_front.sv
// charge rate and mode select, master reset and supervision logic
// assumes pin qualifiers give 2-bit tri-level codes and 1-bit
// comparator flags, all asynchronous to mclk; avalon-mm slave on mclk
`default_nettype none
module charge_front
   import charge_pkg::*;
#(
   parameter int US_DIV   = US_CYCLES,
   parameter int MS_DIV   = US_PER_MS
) (
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic        ce,
   input  wire select_s     select_pins,
   input  wire sense_s      sense_pins,
   input  wire logic        master_reset_low,
   input  wire logic [3:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   output logic             charge_drive,
   output logic             discharge_drive,
   output logic             fast_charge_lamp_low,
   output logic             maintenance_lamp_low,
   output logic             polling_lamp_low
);
   // ************************************************************
   // input synchronisers
   // ************************************************************
   select_s sel_m_q, sel_s_q, sel_q;
   sense_s  sn_m_q, sn_s_q;
   logic    mrl_m_q, mrl_s_q;

   // two flops on every pin before use
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sel_m_q <= '0;
         sel_s_q <= '0;
         sn_m_q  <= '0;
         sn_s_q  <= '0;
         mrl_m_q <= 1'b1;
         mrl_s_q <= 1'b1;
      end else if (ce) begin
         sel_m_q <= select_pins;
         sel_s_q <= sel_m_q;
         sn_m_q  <= sense_pins;
         sn_s_q  <= sn_m_q;
         mrl_m_q <= master_reset_low;
         mrl_s_q <= mrl_m_q;
      end
   end

   // ************************************************************
   // nominal time base
   // ************************************************************
   logic [15:0] us_cnt_q, ms_cnt_q;
   wire         us_tick = (us_cnt_q == 16'(US_DIV - 1));
   wire         ms_tick = us_tick && (ms_cnt_q == 16'(MS_DIV - 1));

   // one tick per nominal microsecond and millisecond
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         us_cnt_q <= 16'h0000;
         ms_cnt_q <= 16'h0000;
      end else if (ce) begin
         us_cnt_q <= us_tick ? 16'h0000 : us_cnt_q + 16'h0001;
         if (ms_tick)
            ms_cnt_q <= 16'h0000;
         else if (us_tick)
            ms_cnt_q <= ms_cnt_q + 16'h0001;
      end
   end

   // ************************************************************
   // master reset qualifier and power-up
   // ************************************************************
   logic [31:0] ctrl_q;
   logic [9:0]  rst_ms_q;
   logic        hold_q;
   logic [1:0]  por_q;
   wire         rst_req = !mrl_s_q || ctrl_q[CTRL_RST_BIT];
   wire         por_done = (por_q == 2'(POR_CYCLES));

   // low must outlast the reset time before the device resets
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rst_ms_q <= 10'h000;
         hold_q   <= 1'b0;
         por_q    <= 2'h0;
      end else if (ce) begin
         if (!por_done)
            por_q <= por_q + 2'h1;
         if (!rst_req) begin
            rst_ms_q <= 10'h000;
            hold_q   <= 1'b0;
         end else if (ms_tick && !hold_q) begin
            if (rst_ms_q == 10'(RESET_MS))
               hold_q <= 1'b1;
            else
               rst_ms_q <= rst_ms_q + 10'h001;
         end
      end
   end

   // ************************************************************
   // settings and timers
   // ************************************************************
   state_e      state_q, state_d;
   mode_e       mode_q;
   logic [3:0]  rate_q;
   logic [31:0] st_ms_q, total_ms_q, flash_ms_q;
   logic [3:0]  pulses_q;
   logic        flash_q;
   wire         leave_reset = (state_q == ST_RESET) && (state_d != ST_RESET);
   wire         new_state = (state_d != state_q);
   wire [31:0]  top_ms = 32'(TOP_S[rate_q] * 1000);
   wire [31:0]  maint_ms = 32'(MAINT_S[rate_q] * 1000);
   wire [31:0]  fast_ms = 32'(FAST_MIN[rate_q] * 60_000);
   wire [31:0]  period_ms = (state_q == ST_POLL) ? 32'(POLL_PERIOD_MS) :
                            (state_q == ST_TOP)  ? top_ms :
                            (state_q == ST_MAINT) ? maint_ms : 32'hFFFF_FFFF;
   wire [31:0]  on_ms = (state_q == ST_POLL) ? 32'(POLL_ON_MS) :
                        32'(PULSE_MS);
   wire         pulse_on = (st_ms_q < on_ms);
   wire         wrap = ms_tick && (st_ms_q == period_ms - 32'h1);
   wire         flash_wrap = ms_tick && (flash_ms_q == 32'(FLASH_MS - 1));
   wire mode_e  mode_pick = mode_decode(sel_s_q.mode_a, sel_s_q.mode_b);

   // latch selects when reset ends; nothing else can change them
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sel_q  <= '0;
         mode_q <= M_FAST;
         rate_q <= 4'h7;
      end else if (ce && leave_reset) begin
         sel_q  <= sel_s_q;
         mode_q <= mode_pick;
         rate_q <= rate_index(sel_s_q.rate_a, sel_s_q.rate_b);
      end
   end

   // stage, total and flash timers in nominal milliseconds
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st_ms_q    <= 32'h0;
         total_ms_q <= 32'h0;
         flash_ms_q <= 32'h0;
         flash_q    <= 1'b0;
         pulses_q   <= 4'h0;
      end else if (ce) begin
         if (new_state || wrap)
            st_ms_q <= 32'h0;
         else if (ms_tick)
            st_ms_q <= st_ms_q + 32'h1;
         if (state_q == ST_RESET)
            total_ms_q <= 32'h0;
         else if (ms_tick && total_ms_q != 32'hFFFF_FFFF)
            total_ms_q <= total_ms_q + 32'h1;
         flash_ms_q <= flash_wrap ? 32'h0 :
                       (ms_tick ? flash_ms_q + 32'h1 : flash_ms_q);
         if (flash_wrap)
            flash_q <= !flash_q;
         if (new_state)
            pulses_q <= 4'h0;
         else if (wrap && state_q == ST_TOP)
            pulses_q <= pulses_q + 4'h1;
      end
   end

   // ************************************************************
   // charge sequencing
   // ************************************************************
   wire removed = charge_drive && sn_s_q.vin_above_ref;
   wire charging = (state_q == ST_FAST) || (state_q == ST_TOP) ||
                   (state_q == ST_MAINT) || (state_q == ST_COND);
   wire ten_over = (mode_q == M_TEN_HR) && (total_ms_q >= 32'(TEN_HOUR_MS));
   wire fast_ok = !sn_s_q.open_circuit_reference_over_2v3;
   wire seen = ms_tick && (st_ms_q == 32'(POLL_ON_MS - 1)) &&
               !sn_s_q.vin_above_ref;

   // first stage after a battery appears
   function automatic state_e first_stage(input mode_e m);
      unique case (m)
         M_DIRECT:              return ST_MAINT;
         M_COND:                return ST_COND;
         M_DIS_ONLY, M_DIS_CHG: return ST_DISCH;
         default:               return ST_FAST;
      endcase
   endfunction

   // next state
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_RESET:
            if (!hold_q && por_done)
               state_d = (mode_pick == M_TEST)
                         ? ST_TEST : ST_POLL;
         ST_TEST:
            if (ms_tick && st_ms_q == 32'(TEST_MS - 1))
               state_d = ST_SHUT;
         ST_POLL:
            if (seen && (first_stage(mode_q) != ST_FAST || fast_ok))
               state_d = first_stage(mode_q);
         ST_FAST:
            if (total_ms_q >= fast_ms)
               state_d = ST_TOP;
         ST_TOP:
            if (wrap && pulses_q == 4'(TOP_PULSES - 1))
               state_d = ST_MAINT;
         ST_COND:
            if (st_ms_q >= 32'(TEN_HOUR_MS))
               state_d = ST_MAINT;
         ST_DISCH:
            if (sn_s_q.cell_at_1v)
               state_d = (mode_q == M_DIS_ONLY) ? ST_SHUT :
                         (fast_ok ? ST_FAST : ST_DISCH);
         ST_MAINT, ST_SHUT:
            state_d = state_q;
         default:
            state_d = ST_SHUT;
      endcase
      if (charging && removed)
         state_d = ST_POLL;
      if (charging && ten_over)
         state_d = ST_SHUT;
      if (state_q != ST_RESET && sn_s_q.open_circuit_reference_over_4v)
         state_d = ST_SHUT;
      if (hold_q)
         state_d = ST_RESET;
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)
         state_q <= ST_RESET;
      else if (ce)
         state_q <= state_d;
   end

   // ************************************************************
   // drives and lamps
   // ************************************************************
   wire test = (state_q == ST_TEST);
   wire pulsing = (state_q == ST_POLL) || (state_q == ST_TOP) ||
                  (state_q == ST_MAINT);
   wire chg_d = test || (state_q == ST_FAST) || (state_q == ST_COND) ||
                (pulsing && pulse_on);
   wire maint_d = test || (state_q == ST_TOP) || (state_q == ST_MAINT) ||
                  (state_q == ST_COND) || (state_q == ST_DISCH && flash_q);

   // registered outputs; lamps are active low
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         charge_drive         <= 1'b0;
         discharge_drive      <= 1'b0;
         fast_charge_lamp_low <= 1'b1;
         maintenance_lamp_low <= 1'b1;
         polling_lamp_low     <= 1'b1;
      end else if (ce) begin
         charge_drive         <= chg_d;
         discharge_drive      <= test || (state_q == ST_DISCH);
         fast_charge_lamp_low <= !(test || state_q == ST_FAST);
         maintenance_lamp_low <= !maint_d;
         polling_lamp_low     <= !(test || state_q == ST_POLL);
      end
   end

   // ************************************************************
   // avalon-mm slave
   // ************************************************************
   logic       ack_q;
   wire        req = read || write;
   wire [31:0] status_w = {13'h0, discharge_drive, charge_drive, hold_q,
                           sn_s_q, 4'(rate_q), 1'b0, mode_q, state_q};
   wire [31:0] select_w = {16'h0, sel_q, sel_s_q};
   wire [31:0] rd_w = (address == CTRL_ADDR)   ? ctrl_q :
                      (address == STATUS_ADDR) ? status_w :
                      (address == SELECT_ADDR) ? select_w : 32'h0;

   // one wait state, then the answer
   assign waitrequest = req && !ack_q;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ack_q    <= 1'b0;
         readdata <= 32'h0;
         ctrl_q   <= CTRL_RESET;
      end else if (ce) begin
         ack_q <= req && !ack_q;
         if (read && !ack_q)
            readdata <= rd_w;
         if (write && ack_q && address == CTRL_ADDR)
            ctrl_q <= {31'h0, writedata[CTRL_RST_BIT]};
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);

   chk_test_all_on: assert property (
      (state_q == ST_TEST && ce) |=> charge_drive && discharge_drive &&
      !fast_charge_lamp_low && !maintenance_lamp_low && !polling_lamp_low)
      else $error("test stage without all outputs on");
   chk_reset_qualify: assert property (
      $rose(hold_q) |-> $past(rst_ms_q) == 10'(RESET_MS) && $past(rst_req))
      else $error("reset accepted before the qualifying time");
   chk_held_reset: assert property (
      (hold_q && ce) |=> state_q == ST_RESET)
      else $error("not held in reset while reset low");
   chk_shut_stays: assert property (
      (state_q == ST_SHUT && !hold_q && ce) |=> state_q == ST_SHUT)
      else $error("left shutdown without a reset");
   chk_high_ref_shut: assert property (
      (ce && !hold_q && state_q != ST_RESET && sn_s_q.open_circuit_reference_over_4v)
      |=> state_q == ST_SHUT)
      else $error("no shutdown on high reference");
   chk_removal_poll: assert property (
      (ce && !hold_q && state_q == ST_FAST && removed && !ten_over &&
       !sn_s_q.open_circuit_reference_over_4v) |=> state_q == ST_POLL)
      else $error("removal not sent to polling");
   chk_fast_gate: assert property (
      $rose(state_q == ST_FAST) |-> !$past(sn_s_q.open_circuit_reference_over_2v3))
      else $error("fast charge began with high reference");
   chk_select_latch: assert property (
      (state_q != ST_RESET) |=> $stable(sel_q) && $stable(mode_q))
      else $error("settings changed outside reset");
   chk_test_mode: assert property (
      $rose(state_q == ST_TEST) |-> mode_q == M_TEST)
      else $error("test stage without test mode");
   chk_ten_hour_cap: assert property (
      (charging && ten_over && ce && !hold_q) |=> state_q == ST_SHUT)
      else $error("ten hour cap exceeded");
endmodule
`default_nettype wire

//--- verification/battery_model.sv
// far-side model: current source, cell divider and reference comparators
// assumes the bench sets battery presence and the reference levels
`default_nettype none
module battery_model
   import charge_pkg::*;
(
   input  wire logic mclk,
   input  wire logic charge_drive,
   input  wire logic discharge_drive,
   input  wire logic present,
   input  wire logic ref_hi,
   input  wire logic ref_max,
   output var  sense_s sense
);
   timeunit 1ns;
   timeprecision 100ps;
   int dis_n = 0;
   // an open source lifts the divided voltage over the reference
   assign sense = {charge_drive & ~present,
                   ref_hi,
                   ref_max,
                   dis_n > 40};
   // cell sags under the discharge load and recovers on charge
   always @(posedge mclk)
      dis_n <= discharge_drive ? dis_n + 1 : (charge_drive ? 0 : dis_n);
endmodule
`default_nettype wire

//--- verification/test_charge_front.sv
// self-checking bench for the charge mode front end
// assumes short time base US_DIV=1, MS_DIV=2: one ms is two cycles
`default_nettype none
module test_charge_front
   import charge_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        mclk = 1'b0;
   logic        nrst = 1'b0;
   logic        master_reset_low = 1'b1;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [3:0]  address = 4'h0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] rd;
   select_s     select_pins = 8'h55;
   logic        present = 1'b0;
   logic        ref_hi = 1'b0;
   logic        ref_max = 1'b0;
   sense_s      sense_pins;
   wire logic [31:0] readdata;
   wire logic   waitrequest, charge_drive, discharge_drive;
   wire logic   fast_charge_lamp_low, maintenance_lamp_low, polling_lamp_low;
   int          n_errors = 0;
   int          num_checks = 0;
   // select pairs, table order gives the rate index
   int pa [9] = '{0, 0, 0, 2, 2, 2, 1, 1, 1};
   int pb [9] = '{0, 2, 1, 0, 1, 2, 0, 1, 2};
   int ma [9] = '{0, 0, 1, 1, 2, 2, 2, 0, 3};
   int mb [9] = '{0, 2, 1, 0, 0, 1, 2, 1, 3};
   int me [9] = '{0, 1, 2, 3, 4, 5, 6, 2, 2};

   // 50 percent duty clock
   always #10 mclk = ~mclk;

   charge_front #(.US_DIV(1), .MS_DIV(2)) charge_front_i (
      .mclk, .nrst, .ce(1'b1), .select_pins, .sense_pins, .master_reset_low,
      .address, .read, .write, .writedata, .readdata, .waitrequest,
      .charge_drive, .discharge_drive, .fast_charge_lamp_low,
      .maintenance_lamp_low, .polling_lamp_low);
   battery_model battery_model_i (.mclk, .charge_drive, .discharge_drive,
      .present, .ref_hi, .ref_max, .sense(sense_pins));

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, got);
      num_checks++;
      if (got !== exp) begin
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
         n_errors++;
      end
   endtask
   // one avalon access, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] wd);
      int k;
      k = 0;
      @(posedge mclk);
      address <= a;
      writedata <= wd;
      read <= ~wr;
      write <= wr;
      do begin
         @(posedge mclk);
         k++;
      end while (waitrequest !== 1'b0 && k < 50);
      if (k >= 50) begin
         n_errors++;
         conclude();
      end
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic field(input string what, input int lsb, w,
                        input logic [31:0] exp);
      bus(1'b0, STATUS_ADDR, 32'h0);
      check(what, exp, (rd >> lsb) & ((32'h1 << w) - 32'h1));
   endtask
   task automatic wait_state(input logic [3:0] s, input int lim);
      int k;
      k = 0;
      do begin
         bus(1'b0, STATUS_ADDR, 32'h0);
         k++;
      end while (rd[3:0] !== s && k < lim);
      check("state", s, rd[3:0]);
      if (rd[3:0] !== s) conclude();
   endtask
   // cycles until charge_drive reaches lvl, within lo..hi
   task automatic span(input logic lvl, input int lo, hi);
      int k;
      k = 0;
      while (charge_drive !== lvl && k < 5000) begin
         @(posedge mclk);
         k++;
      end
      num_checks++;
      if (k < lo || k > hi) begin
         $display("mismatch span expected %0d..%0d seen %0d", lo, hi, k);
         n_errors++;
         if (k >= 5000) conclude();
      end
   endtask
   task automatic power_up(input select_s s);
      @(posedge mclk);
      nrst <= 1'b0;
      select_pins <= s;
      repeat (6) @(posedge mclk);
      nrst <= 1'b1;
   endtask

   initial begin
      // every rate pair and every mode after a power-up reset
      for (int i = 0; i < 9; i++) begin
         power_up({pa[i][1:0], pb[i][1:0],
                   ma[i][1:0], mb[i][1:0]});
         repeat (8) @(posedge mclk);
         field("rate", 8, 4, i);
         field("mode", 4, 3, me[i]);
      end
      $display("test decode done");
      // polling pulses with no battery, then fast charge gate, removal and high reference shutdown
      span(1'b0, 0, 300);
      span(1'b1, 0, 1300);
      check("poll lamp", 1'b0, polling_lamp_low);
      span(1'b0, 198, 202);
      span(1'b1, 1046, 1050);
      present <= 1'b1;
      ref_hi <= 1'b1;
      repeat (3000) @(posedge mclk);
      bus(1'b0, STATUS_ADDR, 32'h0);
      check("fast held", 1'b0, rd[3:0] == ST_FAST);
      ref_hi <= 1'b0;
      wait_state(ST_FAST, 2000);
      check("fast lamp", 1'b0, fast_charge_lamp_low);
      present <= 1'b0;
      wait_state(ST_POLL, 5);
      ref_max <= 1'b1;
      wait_state(ST_SHUT, 5);
      ref_max <= 1'b0;
      repeat (100) @(posedge mclk);
      field("state", 0, 4, ST_SHUT);
      check("charge off", 1'b0, charge_drive);
      $display("test supervision done");
      // short master reset ignored, new selects wait for a reset
      select_pins <= 8'h52;
      present <= 1'b1;
      master_reset_low <= 1'b0;
      repeat (600) @(posedge mclk);
      master_reset_low <= 1'b1;
      repeat (10) @(posedge mclk);
      field("state", 0, 4, ST_SHUT);
      field("mode", 4, 3, M_FAST);
      bus(1'b0, SELECT_ADDR, 32'h0);
      check("select", 32'h6F52, rd & 32'hFFFF);
      bus(1'b1, CTRL_ADDR, 32'h1);
      repeat (1500) @(posedge mclk);
      field("state", 0, 4, ST_RESET);
      bus(1'b0, CTRL_ADDR, 32'h0);
      check("ctrl", 32'h1, rd);
      bus(1'b0, 4'hC, 32'h0);
      check("unmapped", 32'h0, rd);
      bus(1'b1, CTRL_ADDR, 32'h0);
      wait_state(ST_MAINT, 1000);
      field("mode", 4, 3, M_DIRECT);
      check("maint lamp", 1'b0, maintenance_lamp_low);
      $display("test master reset done");
      // system test: everything on for one second, then shut
      power_up(8'h00);
      span(1'b1, 0, 20);
      check("lamps", 4'h8, {discharge_drive, fast_charge_lamp_low,
         maintenance_lamp_low, polling_lamp_low});
      span(1'b0, 1996, 2004);
      wait_state(ST_SHUT, 3);
      $display("test system test done");
      // discharge, then charge or stop; conditioning charge
      power_up(8'h58);
      wait_state(ST_DISCH, 1000);
      check("discharge on", 1'b1, discharge_drive);
      wait_state(ST_FAST, 100);
      check("discharge off", 1'b0, discharge_drive);
      power_up(8'h54);
      wait_state(ST_DISCH, 1000);
      wait_state(ST_SHUT, 100);
      check("discharge stop", 1'b0, discharge_drive);
      power_up(8'h59);
      wait_state(ST_COND, 1000);
      check("cond charge", 1'b1, charge_drive);
      check("cond lamp", 1'b0, maintenance_lamp_low);
      $display("test discharge done");
      conclude();
   end
   // watchdog for a hung run
   initial begin
      repeat (100000) @(posedge mclk);
      n_errors++;
      conclude();
   end
endmodule
`default_nettype wire
